/* test/cgs_host.sv */
// two-wire management bus host model driving scl and releasing sda
`timescale 1ns/10ps
`default_nettype none
module cgs_host #(
    parameter logic [6:0] ADDR = 7'h6A
) (
    input  wire logic sys_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    logic [7:0] rd [0:8];
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // data moves two cycles into the six-cycle low phase, one cycle before the device answer changes
    task automatic bit_io(input logic b, output logic s);
        tk(2);
        sda_drv <= b;
        tk(4);
        scl <= 1'b1;
        tk(3);
        s = sda;
        tk(3);
        scl <= 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic a,
                           output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, ack);
    endtask
    // serves as first and repeated start alike
    task automatic start();
        tk(2);
        sda_drv <= 1'b1;
        tk(3);
        scl <= 1'b1;
        tk(6);
        sda_drv <= 1'b0;
        tk(6);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tk(2);
        sda_drv <= 1'b0;
        tk(4);
        scl <= 1'b1;
        tk(6);
        sda_drv <= 1'b1;
        tk(6);
    endtask
    task automatic write1(input logic [6:0] a, input logic [7:0] idx,
                          input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       k0, k1, k2, k3;
        start();
        byte_io({a, 1'b0}, 1'b1, q, k0);
        byte_io(idx, 1'b1, q, k1);
        byte_io(8'h01, 1'b1, q, k2);
        byte_io(d, 1'b1, q, k3);
        stop();
        ok = !(k0 | k1 | k2 | k3);
    endtask
    // count byte lands in rd[0], data bytes after it
    task automatic readn(input logic [7:0] idx, input int n,
                         output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2, x;
        start();
        byte_io({ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(idx, 1'b1, q, a1);
        start();
        byte_io({ADDR, 1'b1}, 1'b1, q, a2);
        for (int k = 0; k <= n; k++)
            byte_io(8'hFF, k == n, rd[k], x);
        stop();
        ok = !(a0 | a1 | a2);
    endtask
endmodule
`default_nettype wire

/* test/cgs_regs_properties.sv */
// pin level checks of the status register block
`timescale 1ns/10ps
`default_nettype none
module cgs_regs_properties (
    input wire logic                 sys_clk,
    input wire logic                 resetn,
    input wire logic                 spread_enable_pin,
    input wire logic                 scl_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe,
    input wire cgs_pkg::cgs_spread_t spread_state,
    input wire logic                 pll_input_filter
);
    import cgs_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_reset_idle: assert property ($rose(resetn) |->
        !sda_oe && !pll_input_filter && spread_state == SPREAD_OFF)
        else $error("outputs not idle after reset");
    a_sda_low: assert property (sda_out == 1'b0)
        else $error("sda data value not low");
    a_oe_rise: assert property ($rose(sda_oe) |->
        !scl_in && !$past(scl_in) && !$past(scl_in, 2))
        else $error("sda drive began too soon");
    a_oe_fall: assert property ($fell(sda_oe) |->
        !scl_in && !$past(scl_in, 2))
        else $error("sda released too soon");
    a_oe_hold: assert property (scl_in && $past(scl_in) |->
        $stable(sda_oe))
        else $error("sda drive moved while scl high");
    a_oe_stands: assert property ($rose(sda_oe) |->
        sda_oe [*8])
        else $error("sda drive too short");
    a_pll_timing: assert property ($changed(pll_input_filter) |->
        !scl_in && !$past(scl_in, 2))
        else $error("pll source moved outside a write");
    a_state_pin: assert property (
        $changed(spread_state) && scl_in |->
        spread_state == {1'b0, $past(spread_enable_pin, 2)} ||
        spread_state == {1'b0, $past(spread_enable_pin, 4)})
        else $error("spread state not following pin");
    c_read_drive: cover property ($rose(sda_oe));
    c_pll_set: cover property ($rose(pll_input_filter));
    c_state_max: cover property (spread_state == SPREAD_0P5);
endmodule
bind cgs_regs cgs_regs_properties i_cgs_regs_properties (
    .sys_clk(sys_clk), .resetn(resetn),
    .spread_enable_pin(spread_enable_pin), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .spread_state(spread_state),
    .pll_input_filter(pll_input_filter));
`default_nettype wire

/* test/tb_cgs_regs.sv */
// self-checking bench for the clock generator status registers
`timescale 1ns/10ps
`default_nettype none
module tb_cgs_regs;
    import cgs_pkg::*;
    localparam int PTW = 32;
    localparam int REF = 1000;
    // arbitrary identification values
    localparam logic [7:0] ID_RP   = 8'h69;
    localparam logic [7:0] ID_PART = 8'hC5;
    localparam logic [15:0] DELTA =
        16'(REF - PTW * PT_PERIOD_NS / SYS_PERIOD_NS);
    logic sys_clk = 1'b0;
    logic pt_clk  = 1'b0;
    logic resetn  = 1'b0;
    logic lost_n  = 1'b1;
    logic pin     = 1'b1;
    logic scl, sda_drv, sda_out, sda_oe, pll_f, ok;
    cgs_spread_t st;
    logic [7:0] v3, v6, v10, e6;
    int fail_count = 0;
    int tests_run  = 0;
    wire logic sda = sda_drv & (sda_oe ? sda_out : 1'b1);
    always #2.5 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #80 pt_clk = ~pt_clk;
    end
    cgs_regs #(.PT_WINDOW_CYCLES(PTW), .REF_EXPECT_CYCLES(REF),
        .REV_CODE(ID_RP[7:4]), .VENDOR_CODE(ID_RP[3:0]),
        .PART_CODE(ID_PART)) i_cgs_regs (
        .sys_clk(sys_clk), .resetn(resetn), .platform_time_clock(pt_clk),
        .platform_time_lost_n(lost_n), .spread_enable_pin(pin),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .spread_state(st), .pll_input_filter(pll_f));
    cgs_host i_cgs_host (.sys_clk(sys_clk), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [7:0] exp6(input logic [7:0] v, input logic p);
        logic [1:0] s;
        s = v[2] ? v[1:0] : (p ? PIN_SPREAD_STATE : SPREAD_OFF);
        return {1'b0, s, p, v[3:0]};
    endfunction
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        i_cgs_host.write1(BUS_ADDR_DEFAULT, idx, d, ok);
    endtask
    task automatic win(input int n);
        repeat (n * PTW * 32 + 40) @(posedge sys_clk);
    endtask
    task automatic rdd(input logic [15:0] e);
        i_cgs_host.readn(REG_PT_CTRL, 3, ok);
        chk(i_cgs_host.rd[2], e[7:0]);
        chk(i_cgs_host.rd[3], e[15:8]);
    endtask
    initial begin
        repeat (90000) @(posedge sys_clk);
        fail_count++;
        conclude();
    end
    initial begin
        void'($urandom(51019));
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        i_cgs_host.readn(REG_PT_CTRL, 8, ok);
        chk(i_cgs_host.rd[0], 8'h08);
        chk(i_cgs_host.rd[1], 8'h80);
        chk(i_cgs_host.rd[4], exp6(8'h01, 1'b1));
        chk(i_cgs_host.rd[5], 8'h00);
        chk(i_cgs_host.rd[7], ID_PART);
        chk(i_cgs_host.rd[8], 8'h08);
        i_cgs_host.write1(7'h15, REG_SPREAD, 8'h0F, ok);
        chk({7'h0, ok}, 8'h00);
        // a refused frame must leave the pll source untouched
        chk({7'h0, pll_f}, 8'h00);
        wr(REG_VENDOR_REV, 8'hFF);
        wr(REG_PART_ID, 8'h00);
        wr(8'h0B, 8'hFF);
        i_cgs_host.readn(8'h0B, 1, ok);
        chk(i_cgs_host.rd[1], 8'h00);
        for (int i = 0; i < 6; i++) begin
            v3 = 8'($urandom);
            v6 = (i < 2) ? 8'h06 + 8'(i) : 8'($urandom);
            v10 = 8'($urandom);
            lost_n <= 1'($urandom);
            pin <= 1'($urandom);
            wr(REG_PT_CTRL, v3);
            wr(REG_SPREAD, v6);
            wr(REG_BYTE_COUNT, v10);
            e6 = exp6(v6, pin);
            i_cgs_host.readn(REG_PT_CTRL, 8, ok);
            chk(i_cgs_host.rd[0], v10 & 8'h3F);
            chk(i_cgs_host.rd[1], {lost_n, v3[6:5], 5'h0});
            chk(i_cgs_host.rd[4], e6);
            chk(i_cgs_host.rd[6], ID_RP);
            chk(i_cgs_host.rd[7], ID_PART);
            chk(i_cgs_host.rd[8], v10 & 8'h3F);
            chk({6'h0, st}, {6'h0, e6[6:5]});
            chk({7'h0, pll_f}, {7'h0, v6[3]});
        end
        wr(REG_PT_CTRL, 8'h00);
        win(3);
        wr(REG_PT_CTRL, 8'h40);
        rdd(DELTA);
        wr(REG_PT_CTRL, 8'h20);
        rdd(16'h0000);
        wr(REG_PT_CTRL, 8'h40);
        win(3);
        rdd(16'h0000);
        wr(REG_PT_CTRL, 8'h00);
        win(3);
        wr(REG_PT_CTRL, 8'h40);
        rdd(DELTA);
        conclude();
    end
endmodule
`default_nettype wire

/* verilog/cgs_pkg.sv */
// constants, types and state layouts of the clock generator status registers
package cgs_pkg;

    // register indices on the management bus
    localparam logic [7:0] REG_PT_CTRL    = 8'h03;
    localparam logic [7:0] REG_DELTA_LO   = 8'h04;
    localparam logic [7:0] REG_DELTA_HI   = 8'h05;
    localparam logic [7:0] REG_SPREAD     = 8'h06;
    localparam logic [7:0] REG_RSVD_SEVEN = 8'h07;
    localparam logic [7:0] REG_VENDOR_REV = 8'h08;
    localparam logic [7:0] REG_PART_ID    = 8'h09;
    localparam logic [7:0] REG_BYTE_COUNT = 8'h0A;

    // field positions
    localparam int PT_LOST_BIT      = 7;
    localparam int FREEZE_BIT       = 6;
    localparam int CLEAR_BIT        = 5;
    localparam int STATE_MSB        = 6;
    localparam int STATE_LSB        = 5;
    localparam int PIN_BIT          = 4;
    localparam int PLL_SRC_BIT      = 3;
    localparam int SW_CTRL_BIT      = 2;
    localparam int SEL_MSB          = 1;
    localparam int SEL_LSB          = 0;
    localparam int COUNT_MSB        = 5;

    localparam logic [5:0] BYTE_COUNT_RESET = 6'h08;

    // spread encodings
    typedef logic [1:0] cgs_spread_t;
    localparam cgs_spread_t SPREAD_OFF  = 2'h0;
    localparam cgs_spread_t SPREAD_0P3  = 2'h1;
    localparam cgs_spread_t SPREAD_0P5  = 2'h3;
    // state taken when the spread-enable pin is high
    localparam cgs_spread_t PIN_SPREAD_STATE = SPREAD_0P3;

    // timing
    localparam int SYS_PERIOD_NS     = 5;
    localparam int PT_PERIOD_NS      = 160;
    localparam int MEAS_WINDOW_NS    = 5000000;
    localparam int PT_WINDOW_CYCLES  = MEAS_WINDOW_NS / PT_PERIOD_NS;
    localparam int REF_EXPECT_CYCLES = MEAS_WINDOW_NS / SYS_PERIOD_NS;

    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] WARM_DONE    = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT      = 4'h7;
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h6A;

    typedef enum {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} cgs_bus_st_e;
    typedef enum {RX_ADDR, RX_CMD, RX_COUNT, RX_DATA} cgs_rx_kind_e;

    // one sampling stage of everything arriving from outside sys_clk
    typedef struct packed {
        logic scl;
        logic sda;
        logic lost_n;
        logic spread;
        logic pt_tog;
    } cgs_pins_s;

    typedef struct packed {
        cgs_pins_s    sync1;
        cgs_pins_s    sync2;
        cgs_pins_s    sync3;
        cgs_bus_st_e  st;
        cgs_rx_kind_e rx_kind;
        logic [3:0]   bit_cnt;
        logic [7:0]   shift;
        logic [7:0]   index;
        logic         read_dir;
        logic         host_ack;
        logic         sda_oe;
        logic         sda_out;
        logic         freeze;
        logic         clear;
        logic         pll_src;
        logic         sw_ctrl;
        cgs_spread_t  spread_sel;
        logic [5:0]   byte_count;
        logic [15:0]  delta;
        logic [15:0]  prev;
        logic [23:0]  ref_cnt;
        logic [1:0]   warm;
        logic [1:0]   strap_cnt;
        logic         strap_done;
        cgs_spread_t  spread_state;
        logic         pll_filter;
    } cgs_top_s;

    typedef struct packed {
        logic        rst_s1;
        logic        rst_s2;
        logic [23:0] cnt;
        logic        tog;
    } cgs_pt_s;

endpackage

/* verilog/cgs_pt_window.sv */
// measurement window marker running on the platform time clock
`timescale 1ns/10ps
`default_nettype none
module cgs_pt_window #(
    parameter int PT_WINDOW_CYCLES = cgs_pkg::PT_WINDOW_CYCLES
) (
    input  wire logic platform_time_clock,
    input  wire logic resetn,
    output logic      window_toggle
);
    import cgs_pkg::*;

    localparam logic [23:0] WIN_LAST = 24'(PT_WINDOW_CYCLES - 1);

    cgs_pt_s r_ff;
    cgs_pt_s nxt_r;

    always_comb begin
        nxt_r = r_ff;
        // local release of reset so the counter starts cleanly
        nxt_r.rst_s1 = 1'b1;
        nxt_r.rst_s2 = r_ff.rst_s1;
        if (r_ff.rst_s2) begin
            if (r_ff.cnt == WIN_LAST) begin
                nxt_r.cnt = 24'h000000;
                // a toggle, not a pulse, so the slow edge survives crossing
                nxt_r.tog = ~r_ff.tog;
            end else begin
                nxt_r.cnt = r_ff.cnt + 24'h000001;
            end
        end
    end

    always_ff @(posedge platform_time_clock or negedge resetn) begin
        if (!resetn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign window_toggle = r_ff.tog;

endmodule
`default_nettype wire

/* verilog/cgs_regs.sv */
// status and configuration registers behind the two-wire management bus
`timescale 1ns/10ps
`default_nettype none

// How it works
// - byte 3 bit 7 reads the live platform-time-lost level
// - byte 3 bit 6 freezes updates of bytes 4 and 5, reset 0
// - byte 3 bit 5 forces bytes 4 and 5 to zero, reset 0
// - byte 4 reads low eight bits of averaged ppm difference
// - byte 5 holds difference bits 14..8 and sign in bit 7
// - byte 6 two-bit field reports the active spread state
// - byte 6 bit 4 reads the live spread-enable pin
// - byte 6 bit 3 picks spread pll input, crystal or filter pll
// - byte 6 bit 2 picks pin or software spread control
// - byte 6 bits 1..0 spread select, reset from pin at power-up
// - byte 8 reads revision code high, vendor code low
// - byte 9 reads an eight-bit part identification value
// - byte 10 bits 5..0 block read count, reset eight
// - byte 7 and bytes 11 to 16 are reserved
// - block read returns byte count first, then bytes from index
module cgs_regs #(
    parameter int PT_WINDOW_CYCLES  = cgs_pkg::PT_WINDOW_CYCLES,
    parameter int REF_EXPECT_CYCLES = cgs_pkg::REF_EXPECT_CYCLES,
    parameter logic [6:0] BUS_ADDR  = cgs_pkg::BUS_ADDR_DEFAULT,
    // identification values below are arbitrary
    parameter logic [3:0] REV_CODE    = 4'h3,
    parameter logic [3:0] VENDOR_CODE = 4'hA,
    parameter logic [7:0] PART_CODE   = 8'h5C
) (
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    input  wire logic          platform_time_clock,
    input  wire logic          platform_time_lost_n,
    input  wire logic          spread_enable_pin,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe,
    output cgs_pkg::cgs_spread_t spread_state,
    output logic               pll_input_filter
);
    import cgs_pkg::*;

    localparam logic signed [25:0] REF_EXPECT = 26'(REF_EXPECT_CYCLES);
    localparam logic signed [25:0] SAT_HI     = 26'sh0007FFF;
    localparam logic signed [25:0] SAT_LO     = -26'sh0008000;
    localparam logic [23:0]        REF_START  = 24'h000001;
    localparam logic [23:0]        REF_MAX    = 24'hFFFFFF;

    cgs_top_s r_ff;
    cgs_top_s nxt_r;
    logic     pt_toggle;

    cgs_pt_window #(
        .PT_WINDOW_CYCLES (PT_WINDOW_CYCLES)
    ) u_window (
        .platform_time_clock (platform_time_clock),
        .resetn              (resetn),
        .window_toggle       (pt_toggle)
    );

    function automatic logic [15:0] sat16(input logic signed [25:0] v);
        logic [15:0] res;
        res = 16'h0000;
        if (v > SAT_HI) begin
            res = 16'h7FFF;
        end else if (v < SAT_LO) begin
            res = 16'h8000;
        end else begin
            res = v[15:0];
        end
        return res;
    endfunction

    function automatic logic [7:0] read_byte(input cgs_top_s s,
                                             input logic [7:0] idx);
        logic [7:0] d;
        d = 8'h00;
        unique case (idx)
            REG_PT_CTRL: begin
                d[PT_LOST_BIT] = s.sync2.lost_n;
                d[FREEZE_BIT]  = s.freeze;
                d[CLEAR_BIT]   = s.clear;
            end
            REG_DELTA_LO: d = s.delta[7:0];
            REG_DELTA_HI: d = s.delta[15:8];
            REG_SPREAD: begin
                d[STATE_MSB:STATE_LSB] = s.spread_state;
                d[PIN_BIT]     = s.sync2.spread;
                d[PLL_SRC_BIT] = s.pll_src;
                d[SW_CTRL_BIT] = s.sw_ctrl;
                d[SEL_MSB:SEL_LSB] = s.spread_sel;
            end
            REG_VENDOR_REV: d = {REV_CODE, VENDOR_CODE};
            REG_PART_ID:    d = PART_CODE;
            REG_BYTE_COUNT: d = {2'b00, s.byte_count};
            // reserved and out-of-block indices read zero
            default:        d = 8'h00;
        endcase
        return d;
    endfunction

    always_comb begin
        logic             scl_rise;
        logic             scl_fall;
        logic             start_c;
        logic             stop_c;
        logic             pt_event;
        logic [7:0]       tx;
        logic signed [25:0] diff;
        logic [15:0]      sample;
        logic [16:0]      avg;
        cgs_spread_t      pin_state;
        scl_rise  = 1'b0;
        scl_fall  = 1'b0;
        start_c   = 1'b0;
        stop_c    = 1'b0;
        pt_event  = 1'b0;
        tx        = 8'h00;
        diff      = 26'sh0;
        sample    = 16'h0000;
        avg       = 17'h00000;
        pin_state = SPREAD_OFF;
        nxt_r     = r_ff;

        // three-stage capture of everything that is not on sys_clk; values come from the second stage, edges from the second and third
        nxt_r.sync1.scl    = scl_in;
        nxt_r.sync1.sda    = sda_in;
        nxt_r.sync1.lost_n = platform_time_lost_n;
        nxt_r.sync1.spread = spread_enable_pin;
        nxt_r.sync1.pt_tog = pt_toggle;
        nxt_r.sync2        = r_ff.sync1;
        nxt_r.sync3        = r_ff.sync2;

        scl_rise = r_ff.sync2.scl & ~r_ff.sync3.scl;
        scl_fall = ~r_ff.sync2.scl & r_ff.sync3.scl;
        start_c  = r_ff.sync2.scl & r_ff.sync3.scl &
                   r_ff.sync3.sda & ~r_ff.sync2.sda;
        stop_c   = r_ff.sync2.scl & r_ff.sync3.scl &
                   ~r_ff.sync3.sda & r_ff.sync2.sda;
        pt_event = r_ff.sync2.pt_tog ^ r_ff.sync3.pt_tog;

        // strap capture waits for the synchroniser to hold a real value
        if (!r_ff.strap_done) begin
            if (r_ff.strap_cnt == STRAP_SETTLE) begin
                nxt_r.strap_done = 1'b1;
                nxt_r.spread_sel = r_ff.sync2.spread ? PIN_SPREAD_STATE
                                                     : SPREAD_OFF;
            end else begin
                nxt_r.strap_cnt = r_ff.strap_cnt + 2'h1;
            end
        end

        // management bus slave
        if (stop_c) begin
            nxt_r.st     = ST_IDLE;
            nxt_r.sda_oe = 1'b0;
        end else if (start_c) begin
            nxt_r.st      = ST_RX;
            nxt_r.rx_kind = RX_ADDR;
            nxt_r.bit_cnt = 4'h0;
            nxt_r.sda_oe  = 1'b0;
        end else begin
            unique case (r_ff.st)
                ST_IDLE: begin
                end
                ST_RX: begin
                    if (scl_rise && r_ff.bit_cnt != BITS_PER_BYTE) begin
                        nxt_r.shift   = {r_ff.shift[6:0], r_ff.sync2.sda};
                        nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
                    end else if (scl_fall &&
                                 r_ff.bit_cnt == BITS_PER_BYTE) begin
                        nxt_r.sda_oe = 1'b1;
                        nxt_r.st     = ST_RX_ACK;
                        unique case (r_ff.rx_kind)
                            RX_ADDR: begin
                                if (r_ff.shift[7:1] != BUS_ADDR) begin
                                    nxt_r.sda_oe = 1'b0;
                                    nxt_r.st     = ST_IDLE;
                                end else begin
                                    nxt_r.read_dir = r_ff.shift[0];
                                end
                            end
                            RX_CMD:   nxt_r.index = r_ff.shift;
                            RX_COUNT: begin
                            end
                            RX_DATA: begin
                                nxt_r.index = r_ff.index + 8'h01;
                                unique case (r_ff.index)
                                    REG_PT_CTRL: begin
                                        nxt_r.freeze = r_ff.shift[FREEZE_BIT];
                                        nxt_r.clear  = r_ff.shift[CLEAR_BIT];
                                    end
                                    REG_SPREAD: begin
                                        nxt_r.pll_src =
                                            r_ff.shift[PLL_SRC_BIT];
                                        nxt_r.sw_ctrl =
                                            r_ff.shift[SW_CTRL_BIT];
                                        nxt_r.spread_sel =
                                            r_ff.shift[SEL_MSB:SEL_LSB];
                                    end
                                    REG_BYTE_COUNT: begin
                                        nxt_r.byte_count =
                                            r_ff.shift[COUNT_MSB:0];
                                    end
                                    // read-only and reserved bytes drop writes
                                    default: begin
                                    end
                                endcase
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_r.sda_oe  = 1'b0;
                        nxt_r.bit_cnt = 4'h0;
                        if (r_ff.rx_kind == RX_ADDR && r_ff.read_dir) begin
                            // count goes out ahead of the data
                            tx           = {2'b00, r_ff.byte_count};
                            nxt_r.shift  = tx;
                            nxt_r.sda_oe = ~tx[7];
                            nxt_r.st     = ST_TX;
                        end else begin
                            nxt_r.st = ST_RX;
                            unique case (r_ff.rx_kind)
                                RX_ADDR:  nxt_r.rx_kind = RX_CMD;
                                RX_CMD:   nxt_r.rx_kind = RX_COUNT;
                                RX_COUNT: nxt_r.rx_kind = RX_DATA;
                                RX_DATA:  nxt_r.rx_kind = RX_DATA;
                            endcase
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (r_ff.bit_cnt == LAST_BIT) begin
                            nxt_r.sda_oe = 1'b0;
                            nxt_r.st     = ST_TX_ACK;
                        end else begin
                            nxt_r.shift   = {r_ff.shift[6:0], 1'b0};
                            nxt_r.sda_oe  = ~r_ff.shift[6];
                            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        nxt_r.host_ack = ~r_ff.sync2.sda;
                    end else if (scl_fall) begin
                        if (r_ff.host_ack) begin
                            tx            = read_byte(r_ff, r_ff.index);
                            nxt_r.shift   = tx;
                            nxt_r.sda_oe  = ~tx[7];
                            nxt_r.index   = r_ff.index + 8'h01;
                            nxt_r.bit_cnt = 4'h0;
                            nxt_r.st      = ST_TX;
                        end else begin
                            nxt_r.st = ST_IDLE;
                        end
                    end
                end
            endcase
        end

        // frequency difference, one sample per platform window
        if (pt_event) begin
            nxt_r.ref_cnt = REF_START;
            diff   = REF_EXPECT - $signed({2'b00, r_ff.ref_cnt});
            sample = sat16(diff);
            avg    = 17'({sample[15], sample} + {r_ff.prev[15], r_ff.prev});
            if (r_ff.warm != 2'h0) begin
                nxt_r.prev = sample;
            end
            if (r_ff.warm != WARM_DONE) begin
                // first window is partial and the second only loads prev, so nothing is published yet
                nxt_r.warm = r_ff.warm + 2'h1;
            end else if (!r_ff.freeze) begin
                nxt_r.delta = avg[16:1];
            end
        end else if (r_ff.ref_cnt != REF_MAX) begin
            nxt_r.ref_cnt = r_ff.ref_cnt + 24'h000001;
        end
        if (r_ff.clear) begin
            nxt_r.delta = 16'h0000;
        end

        pin_state = r_ff.sync2.spread ? PIN_SPREAD_STATE : SPREAD_OFF;
        nxt_r.spread_state = r_ff.sw_ctrl ? r_ff.spread_sel
                                          : pin_state;
        nxt_r.pll_filter   = r_ff.pll_src;
        nxt_r.sda_out      = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r_ff            <= '0;
            r_ff.st         <= ST_IDLE;
            r_ff.rx_kind    <= RX_ADDR;
            r_ff.byte_count <= BYTE_COUNT_RESET;
            // toggle stages rest at the window toggle's level: no false event
            r_ff.sync1      <= '{pt_tog: 1'b0, default: 1'b1};
            r_ff.sync2      <= '{pt_tog: 1'b0, default: 1'b1};
            r_ff.sync3      <= '{pt_tog: 1'b0, default: 1'b1};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sda_out          = r_ff.sda_out;
    assign sda_oe           = r_ff.sda_oe;
    assign spread_state     = r_ff.spread_state;
    assign pll_input_filter = r_ff.pll_filter;

endmodule
`default_nettype wire
